/* core/dgh_pkg.sv */
// Package for the line gain and hook control register bank.
// Assumes a Wishbone classic slave with 8-bit data registers on a 32-bit bus.
package dgh_pkg;

  // ----------------------------------------
  // Register byte addresses and indices
  // ----------------------------------------
  localparam logic [7:0] DGH_IDX_GAIN = 8'h0F;
  localparam logic [7:0] DGH_IDX_INTL = 8'h10;
  localparam logic [7:0] DGH_IDX_STATUS = 8'h11;
  localparam logic [7:0] DGH_IDX_HOOK = 8'h12;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int DGH_TX_MUTE_BIT = 7;
  localparam int DGH_TX_ATT_LSB = 4;
  localparam int DGH_RX_MUTE_BIT = 3;
  localparam int DGH_RX_GAIN_LSB = 0;
  localparam int DGH_TERM_SQUELCH_BIT = 7;
  localparam int DGH_HOOK_SPEED_BIT = 6;
  localparam int DGH_HOOK_BIT = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] DGH_GAIN_RST = 8'h00;
  localparam logic [7:0] DGH_INTL_RST = 8'h00;

  // ----------------------------------------
  // Timing: off-hook counter lengths in sample periods
  // ----------------------------------------
  localparam int DGH_ONHOOK_FAST = 1024;
  localparam int DGH_ONHOOK_SLOW = 4096;
  localparam int DGH_CNT_W = 13;

  // Transmit attenuation steps (dB)
  typedef enum logic [2:0] {
    DGH_ATT_0DB = 3'b000,
    DGH_ATT_3DB = 3'b001,
    DGH_ATT_6DB = 3'b010,
    DGH_ATT_9DB = 3'b011,
    DGH_ATT_12DB = 3'b100
  } dgh_att_e;

  // Monitor attenuation steps: 0, 1, 2.2, 3.5, 5 dB
  typedef enum logic [2:0] {
    DGH_MON_0DB = 3'b000,
    DGH_MON_1DB = 3'b001,
    DGH_MON_2P2DB = 3'b010,
    DGH_MON_3P5DB = 3'b011,
    DGH_MON_5DB = 3'b100
  } dgh_mon_e;

  // Hook sequencing states
  typedef enum logic [1:0] {
    DGH_ST_ONHOOK = 2'b00,
    DGH_ST_OFFHOOK = 2'b01,
    DGH_ST_RELEASE = 2'b10
  } dgh_state_e;

  // Controls toward the line-side link
  typedef struct packed {
    logic tx_mute;
    dgh_att_e tx_att;
    logic rx_mute;
    logic [2:0] rx_gain;
    dgh_mon_e mon_att;
    logic dc_term_off;
    logic low_dct_voltage;
    logic squelch_en;
  } dgh_line_ctrl_s;

endpackage

/* core/dgh_onhook_timer.sv */
// Off-hook release counter, counts sample strobes down to zero.
// Assumes sample_tick is a one-cycle pulse on clk at the sample rate.
`timescale 1ns/1ps
module dgh_onhook_timer
  import dgh_pkg::*;
#(
  parameter int CNT_W = DGH_CNT_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic start,
  input wire logic [CNT_W-1:0] length,
  input wire logic sample_tick,
  output logic busy
);

  logic [CNT_W-1:0] count_reg;

  // ----------------------------------------
  // Countdown
  // ----------------------------------------
  // Load on start, then one step per sample period
  always_ff @(posedge clk) begin
    if (srst) begin
      count_reg <= '0;
    end else if (ce) begin
      if (start) begin
        count_reg <= length;
      end else if (sample_tick && count_reg != '0) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // Busy while the count runs
  always_ff @(posedge clk) begin
    if (srst) begin
      busy <= 1'b0;
    end else if (ce) begin
      busy <= start || (count_reg > {{(CNT_W-1){1'b0}}, 1'b1}) || (count_reg != '0 && !sample_tick);
    end
  end

endmodule // dgh_onhook_timer

/* core/dgh_regs.sv */
// Line gain and hook control register bank with a Wishbone classic slave.
// Assumes hook_req and sample_tick come from logic on clk; no pins enter here.
//
// Function
// - Gain bit 7 mutes transmit
// - Bits 6:4 pick 0/3/6/9/12 dB
// - Gain bit 3 mutes receive
// - Bits 2:0 set receive gain 0-9 dB
// - Same field sets monitor attenuation
// - Intl bit 7 meaning follows hook
// - Off-hook: DC termination off, 800 ohm
// - On-hook: enhanced ring squelch enabled
// - Bit 6 picks 1024 or 4096 release
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
module dgh_regs
  import dgh_pkg::*;
#(
  parameter int FAST_LEN = DGH_ONHOOK_FAST,
  parameter int SLOW_LEN = DGH_ONHOOK_SLOW
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic hook_req,
  input wire logic sample_tick,
  output dgh_line_ctrl_s line_ctrl,
  output logic offhook,
  output logic releasing
);

  logic [7:0] gain_reg;
  logic [7:0] intl_reg;
  dgh_state_e state_reg;
  dgh_state_e state_next;
  logic timer_start;
  logic timer_busy;
  logic [DGH_CNT_W-1:0] rel_len;
  logic req;
  logic hit;
  logic line_engaged;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // New request only when no ack is pending, so each access acks once
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign hit = (wb_adr_i == DGH_IDX_GAIN) || (wb_adr_i == DGH_IDX_INTL)
    || (wb_adr_i == DGH_IDX_STATUS) || (wb_adr_i == DGH_IDX_HOOK);

  // Ack for mapped, error for unmapped; one cycle each
  always_ff @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= req && hit;
      wb_err_o <= req && !hit;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // hold written value
  // Only byte lane 0 carries the 8-bit fields
  always_ff @(posedge clk) begin
    if (srst) begin
      gain_reg <= DGH_GAIN_RST;
    end else if (ce && req && wb_we_i && wb_sel_i[0] && wb_adr_i == DGH_IDX_GAIN) begin
      gain_reg <= wb_dat_i[7:0];
    end
  end

  // hold written value
  // Low bits of this register belong to other blocks; kept as plain storage
  always_ff @(posedge clk) begin
    if (srst) begin
      intl_reg <= DGH_INTL_RST;
    end else if (ce && req && wb_we_i && wb_sel_i[0] && wb_adr_i == DGH_IDX_INTL) begin
      intl_reg <= wb_dat_i[7:0];
    end
  end

  // Read data, registered with the ack
  always_ff @(posedge clk) begin
    if (srst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce && req && !wb_we_i) begin
      case (wb_adr_i)
        DGH_IDX_GAIN: wb_dat_o <= {24'h00_0000, gain_reg};
        DGH_IDX_INTL: wb_dat_o <= {24'h00_0000, intl_reg};
        DGH_IDX_STATUS: wb_dat_o <= {30'h0000_0000, releasing, offhook};
        DGH_IDX_HOOK: wb_dat_o <= {31'h0000_0000, hook_req};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Hook sequencing
  // ----------------------------------------
  // release length select
  assign rel_len = intl_reg[DGH_HOOK_SPEED_BIT] ? DGH_CNT_W'(SLOW_LEN) : DGH_CNT_W'(FAST_LEN);

  // Next state; a new off-hook request aborts a release
  always_comb begin
    state_next = state_reg;
    timer_start = 1'b0;
    case (state_reg)
      DGH_ST_ONHOOK: begin
        if (hook_req) begin
          state_next = DGH_ST_OFFHOOK;
        end
      end
      DGH_ST_OFFHOOK: begin
        if (!hook_req) begin
          state_next = DGH_ST_RELEASE;
          timer_start = 1'b1;
        end
      end
      DGH_ST_RELEASE: begin
        if (hook_req) begin
          state_next = DGH_ST_OFFHOOK;
        end else if (!timer_busy) begin
          state_next = DGH_ST_ONHOOK;
        end
      end
      default: state_next = DGH_ST_ONHOOK;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= DGH_ST_ONHOOK;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  dgh_onhook_timer #(
    .CNT_W(DGH_CNT_W)
  ) u_timer (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .start(timer_start),
    .length(rel_len),
    .sample_tick(sample_tick),
    .busy(timer_busy)
  );

  // Line counts as off-hook until the release finishes
  assign line_engaged = (state_next != DGH_ST_ONHOOK);

  // Hook status outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      offhook <= 1'b0;
      releasing <= 1'b0;
    end else if (ce) begin
      offhook <= line_engaged;
      releasing <= (state_next == DGH_ST_RELEASE);
    end
  end

  // ----------------------------------------
  // Line controls
  // ----------------------------------------
  // Decoded controls, all registered
  always_ff @(posedge clk) begin
    if (srst) begin
      line_ctrl <= '0;
    end else if (ce) begin
      line_ctrl.tx_mute <= gain_reg[DGH_TX_MUTE_BIT];
      line_ctrl.tx_att <= gain_reg[DGH_TX_ATT_LSB+2] ? DGH_ATT_12DB
        : dgh_att_e'({1'b0, gain_reg[DGH_TX_ATT_LSB +: 2]});
      line_ctrl.rx_mute <= gain_reg[DGH_RX_MUTE_BIT];
      line_ctrl.rx_gain <= gain_reg[DGH_RX_GAIN_LSB +: 3];
      line_ctrl.mon_att <= gain_reg[DGH_RX_GAIN_LSB+2] ? DGH_MON_5DB
        : dgh_mon_e'({1'b0, gain_reg[DGH_RX_GAIN_LSB +: 2]});
      line_ctrl.dc_term_off <= line_engaged && intl_reg[DGH_TERM_SQUELCH_BIT];
      line_ctrl.low_dct_voltage <= line_engaged && intl_reg[DGH_TERM_SQUELCH_BIT];
      line_ctrl.squelch_en <= !line_engaged && intl_reg[DGH_TERM_SQUELCH_BIT];
    end
  end

endmodule // dgh_regs

/* test/dgh_regs_props.sv */
// Checker for the gain and hook register bank ports.
// Assumes ce is held high by the bench.
`timescale 1ns/1ps
module dgh_regs_props
  import dgh_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire dgh_line_ctrl_s line_ctrl,
  input wire logic offhook,
  input wire logic releasing
);
  // ----
  // Properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence gain_wr;
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == DGH_IDX_GAIN;
  endsequence
  ack_timing_a: assert property (taken |=> wb_ack_o ^ wb_err_o)
    else $error("request not answered");
  err_map_a: assert property (taken |=> wb_err_o == ($past(wb_adr_i) < DGH_IDX_GAIN
    || $past(wb_adr_i) > DGH_IDX_HOOK)) else $error("error answer wrong");
  tx_mute_a: assert property (
    gain_wr |=> line_ctrl.tx_mute == $past(wb_dat_i[7])) else $error("tx mute wrong");
  tx_att_a: assert property (gain_wr |=> line_ctrl.tx_att ==
    ($past(wb_dat_i[6]) ? 3'h4 : $past(wb_dat_i[6:4]))) else $error("tx att wrong");
  rx_gain_a: assert property (
    gain_wr |=> line_ctrl.rx_gain == $past(wb_dat_i[2:0])) else $error("rx gain wrong");
  mon_att_a: assert property (gain_wr |=> line_ctrl.mon_att ==
    ($past(wb_dat_i[2]) ? 3'h4 : $past(wb_dat_i[2:0]))) else $error("monitor att wrong");
  hook_split_a: assert property (
    !(line_ctrl.squelch_en && line_ctrl.dc_term_off)) else $error("both meanings active");
  dct_pair_a: assert property (
    line_ctrl.dc_term_off == line_ctrl.low_dct_voltage) else $error("termination split");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held over");
  hook_term_a: assert property (!offhook |-> !line_ctrl.dc_term_off)
    else $error("termination off while on-hook");
  hook_squelch_a: assert property (offhook |-> !line_ctrl.squelch_en)
    else $error("squelch while off-hook");
  release_hook_a: assert property (releasing |-> offhook)
    else $error("release outside off-hook");
  release_end_a: assert property ($fell(offhook) |-> $past(releasing))
    else $error("on-hook without release count");
endmodule // dgh_regs_props

bind dgh_regs dgh_regs_props u_props (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_err_o, .line_ctrl, .offhook, .releasing);

/* test/dgh_line_model.sv */
// Line-side stand-in: supplies the sample strobe.
// Assumes one clock shared with the register bank.
`timescale 1ns/1ps
module dgh_line_model #(
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic srst,
  output logic sample_tick
);
  logic [7:0] div_reg;
  // One strobe every DIV clocks, short so release counts stay quick
  always_ff @(posedge clk) begin
    div_reg <= (srst || div_reg == 8'(DIV - 1)) ? 8'h00 : div_reg + 8'h01;
    sample_tick <= !srst && div_reg == 8'(DIV - 1);
  end
endmodule // dgh_line_model

/* test/dgh_regs_test.sv */
// Self-checking bench for the gain and hook register bank.
// Assumes the line model supplies the sample strobe.
`timescale 1ns/1ps
module dgh_regs_test
  import dgh_pkg::*;
;
  localparam int FAST = 4;
  localparam int SLOW = 16;
  logic clk = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic hook_req = 1'b0, wb_ack_o, wb_err_o, sample_tick, offhook, releasing, err_seen;
  logic [7:0] wb_adr_i = 8'h00, rd;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  dgh_line_ctrl_s line_ctrl;
  int bad_count = 0, num_checks = 0;

  always #12.5 clk = ~clk;

  dgh_regs #(.FAST_LEN(FAST), .SLOW_LEN(SLOW)) dut (.clk, .srst, .ce(1'b1), .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
    .hook_req, .sample_tick, .line_ctrl, .offhook, .releasing);
  dgh_line_model u_line (.clk, .srst, .sample_tick);

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask

  // Classic cycle, held until ack or err is sampled; only the watchdog ends a wait
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rd = wb_dat_o[7:0];
    err_seen = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task t_gain;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      bus(1'b1, DGH_IDX_GAIN, {c[0], c, c[1], c}, 4'h1);
      bus(1'b0, DGH_IDX_GAIN, 8'h00, 4'h1);
      check(rd, {c[0], c, c[1], c});
      check({line_ctrl.tx_mute, line_ctrl.rx_mute}, {c[0], c[1]});
      check(line_ctrl.tx_att, c[2] ? 3'h4 : c);
      check({line_ctrl.rx_gain, line_ctrl.mon_att}, {c, (c[2] ? 3'h4 : c)});
    end
    $display("gain test done");
  endtask

  task t_refuse;
    bus(1'b1, DGH_IDX_GAIN, 8'h5A, 4'h0);
    bus(1'b0, DGH_IDX_GAIN, 8'h00, 4'h1);
    check(rd, 8'hFF);
    bus(1'b0, 8'h20, 8'h00, 4'h1);
    check(err_seen, 1'b1);
    $display("refuse test done");
  endtask

  // Pulse reset in mid-run, then every field is back at its reset value
  task t_reset;
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check(line_ctrl, 32'h0000_0000);
    check({offhook, releasing}, 2'h0);
    bus(1'b0, DGH_IDX_GAIN, 8'h00, 4'h1);
    check(rd, DGH_GAIN_RST);
    bus(1'b0, DGH_IDX_INTL, 8'h00, 4'h1);
    check(rd, DGH_INTL_RST);
    $display("reset test done");
  endtask

  task t_hook(input logic [7:0] v, input int len);
    int n;
    int ticks;
    logic rel_seen;
    bus(1'b1, DGH_IDX_INTL, v, 4'h1);
    check({line_ctrl.dc_term_off, line_ctrl.squelch_en}, {1'b0, v[7]});
    hook_req <= 1'b1;
    repeat (3) @(posedge clk);
    check({offhook, line_ctrl.dc_term_off, line_ctrl.low_dct_voltage,
      line_ctrl.squelch_en}, {1'b1, v[7], v[7], 1'b0});
    bus(1'b0, DGH_IDX_STATUS, 8'h00, 4'h1);
    check(rd, 8'h01);
    bus(1'b0, DGH_IDX_HOOK, 8'h00, 4'h1);
    check(rd, 8'h01);
    hook_req <= 1'b0;
    ticks = 0;
    rel_seen = 1'b0;
    for (n = 0; n < 200 && offhook !== 1'b0; n++) begin
      @(posedge clk);
      if (sample_tick === 1'b1) ticks++;
      if (releasing === 1'b1) rel_seen = 1'b1;
    end
    check(ticks >= len && ticks <= len + 2, 1'b1);
    check({rel_seen, releasing}, 2'h2);
    check({line_ctrl.dc_term_off, line_ctrl.squelch_en}, {1'b0, v[7]});
    bus(1'b0, DGH_IDX_STATUS, 8'h00, 4'h1);
    check(rd, 8'h00);
    $display("hook test done");
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_gain();
    t_refuse();
    t_reset();
    t_hook(8'h80, FAST);
    t_hook(8'hC0, SLOW);
    t_hook(8'h40, SLOW);
    complete_run();
  end

  // Watchdog, well past the expected run
  initial begin
    #(25 * 5000);
    bad_count++;
    complete_run();
  end
endmodule // dgh_regs_test
